// ===== bench/fwb_flash_word_and_buffer_program_tb.sv
// Self-checking bench for the flash program sequencer and its host controller
module fwb_flash_word_and_buffer_program_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fwb_pkg::*;
    logic clk_sys, sys_rst, clkEn, avs_read, avs_write, avs_waitrequest, progBusy, progAborted, progFailed;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, s;
    logic [15:0] shadow [MEM_WORDS];
    logic [15:0] nxt [32];
    logic [15:0] d, p, q;
    logic [11:0] a, wa, base;
    int n, n_errors = 0, checks_done = 0, cycles = 0;
    fwb_flash_if pinsIf();
    fwb_flash_host i_fwb_flash_host(.clk_sys, .sys_rst, .clkEn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .pins(pinsIf.host));
    fwb_flash_dev i_fwb_flash_dev(.clk_sys, .sys_rst, .clkEn, .pins(pinsIf.dev), .progBusy, .progAborted,
        .progFailed);
    fwb_monitor i_fwb_monitor(.clk_sys, .sys_rst, .addr(pinsIf.addr), .avdN(pinsIf.avdN), .ceN(pinsIf.ceN),
        .weN(pinsIf.weN), .oeN(pinsIf.oeN), .hostDataOe(pinsIf.hostDataOe), .devDataOe(pinsIf.devDataOe),
        .dq(pinsIf.dq), .progBusy, .progAborted, .progFailed);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic av(input logic [3:0] ad, input logic w, input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge clk_sys);
        avs_address <= ad;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= wd;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic fop(input logic w, input logic [11:0] ad, input logic [15:0] wd, output logic [15:0] rdv);
        logic [31:0] st;
        av(REG_ADDR, 1'b1, {20'h0, ad}, st);
        av(REG_WDATA, 1'b1, {16'h0, wd}, st);
        av(REG_CTRL, 1'b1, w ? 32'h1 : 32'h2, st);
        do av(REG_STATUS, 1'b0, 32'h0, st); while (st[0] !== 1'b0);
        rdv = st[31:16];
    endtask
    task automatic wr(input logic [11:0] ad, input logic [15:0] wd);
        logic [15:0] x;
        fop(1'b1, ad, wd, x);
    endtask
    task automatic rd(input logic [11:0] ad, output logic [15:0] rdv);
        fop(1'b0, ad, 16'h0, rdv);
    endtask
    task automatic unlock();
        wr(UNLOCK_ADDR1, CMD_UNLOCK1);
        wr(UNLOCK_ADDR2, CMD_UNLOCK2);
    endtask
    task automatic prog(input logic [11:0] ad, input logic [15:0] wd);
        unlock();
        wr(UNLOCK_ADDR1, CMD_PROG);
        wr(ad, wd);
    endtask
    task automatic settle(input logic [11:0] ad, input logic [15:0] wd);
        logic [15:0] x, y;
        rd(ad, x);
        chk({15'h0, x[POLL_BIT]}, {15'h0, ~wd[POLL_BIT]}, "poll bit");
        rd(ad, y);
        chk({15'h0, x[TOGGLE_BIT] ^ y[TOGGLE_BIT]}, 16'h1, "toggle");
        for (int i = 0; i < 40 && x !== y; i++) begin
            x = y;
            rd(ad, y);
        end
        chk(y, shadow[ad], "array word");
    endtask
    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        foreach (shadow[i]) shadow[i] = ERASED_WORD;
        s = $urandom(32'ha1145bac);
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        av(4'h2, 1'b1, 32'hffff, s);
        av(4'h2, 1'b0, 32'h0, s);
        chk(s[15:0], 16'h0, "unmapped read");
        wa = {4'h0, 8'($urandom)};
        a = wa;
        for (int k = 0; k < 3; k++) begin
            d = 16'($urandom) & shadow[a] & 16'hfffe;
            prog(a, d);
            shadow[a] = shadow[a] & d;
            wr(UNLOCK_ADDR1, CMD_RESET);
            chk({15'h0, progBusy}, 16'h1, "busy after command");
            wr(a, CMD_SUSPEND);
            wr(a, CMD_RESUME);
            settle(a, d);
            a = (k == 0) ? {4'h0, 8'($urandom)} : a;
        end
        $display("word programs done");
        base = {4'h1 + 4'($urandom % 14), 3'($urandom), 5'h0};
        for (int k = 0; k < 2; k++) begin
            n = k ? 32 : 1 + $urandom % 31;
            foreach (nxt[i]) nxt[i] = ERASED_WORD;
            unlock();
            wr(base, CMD_BUF_LOAD);
            wr(base, 16'(n - 1));
            for (int j = 0; j < n; j++) begin
                a = base + 12'($urandom % 32);
                d = 16'($urandom) & shadow[a];
                wr(a, d);
                nxt[a[4:0]] = d;
            end
            wr(a, CMD_BUF_CONFIRM);
            foreach (nxt[i]) shadow[base + 12'(i)] &= nxt[i];
            settle(a, d);
            for (int i = 0; i < 32; i++) begin
                rd(base + 12'(i), q);
                chk(q, shadow[base + 12'(i)], "buffer word");
            end
        end
        $display("buffer programs done");
        for (int k = 0; k < 4; k++) begin
            unlock();
            wr(12'h300, CMD_BUF_LOAD);
            wr(12'h300, k == 0 ? 16'h0020 : (k == 3 ? 16'h0000 : 16'h0001));
            if (k != 0) wr(12'h301, 16'h1234);
            if (k != 0) wr(k == 1 ? 12'h401 : (k == 2 ? 12'h321 : 12'h301), 16'h0000);
            rd(12'h301, p);
            rd(12'h301, q);
            chk({15'h0, progAborted}, 16'h1, "aborted");
            chk({13'h0, p[ABORT_BIT], p[LIMIT_BIT], p[TOGGLE_BIT] ^ q[TOGGLE_BIT]}, 16'h5, "abort bits");
            if (k != 0) chk({15'h0, p[POLL_BIT]}, 16'h1, "abort poll");
            wr(12'h300, CMD_RESET);
            rd(12'h301, q);
            chk({15'h0, progAborted} ^ q, shadow[12'h301], "after abort");
        end
        $display("abort cases done");
        prog(wa, 16'hffff);
        for (int i = 0; i < 30 && progFailed !== 1'b1; i++) rd(wa, q);
        rd(wa, q);
        chk({15'h0, q[LIMIT_BIT]}, 16'h1, "limit bit");
        wr(wa, CMD_RESET);
        rd(wa, q);
        chk(q, shadow[wa], "zero kept");
        $display("limit case done");
        prog(wa + 12'h001, 16'h0f0f);
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (shadow[i]) shadow[i] = ERASED_WORD;
        @(posedge clk_sys);
        chk({15'h0, progBusy}, 16'h0, "busy after reset");
        prog(wa + 12'h001, 16'h0f0f);
        shadow[wa + 12'h001] = 16'h0f0f;
        settle(wa + 12'h001, 16'h0f0f);
        $display("reset case done");
        wrap_up();
    end
endmodule

// ===== bench/fwb_monitor.sv
// Concurrent checks on the flash pin bundle and device status flags
module fwb_monitor
    import fwb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [fwb_pkg::ADDR_W-1:0] addr,
    input wire logic avdN,
    input wire logic ceN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic hostDataOe,
    input wire logic devDataOe,
    input wire logic [fwb_pkg::DATA_W-1:0] dq,
    input wire logic progBusy,
    input wire logic progAborted,
    input wire logic progFailed
);
    logic [9:0] busyCnt;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !progBusy) begin
            busyCnt <= 10'h000;
        end else begin
            busyCnt <= busyCnt + 10'h001;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_no_bus_fight: assert property (!(devDataOe && hostDataOe))
        else $error("both ends drive the data bus");
    a_strobe_oe_high: assert property (!weN |-> oeN && !ceN)
        else $error("write strobe without select or with output enable");
    a_avd_then_we: assert property ($fell(weN) |-> $rose(avdN))
        else $error("write strobe not after address phase");
    a_addr_held: assert property (!ceN && $past(!ceN) |-> $stable(addr))
        else $error("address moved while selected");
    a_data_hold: assert property ($rose(weN) |-> hostDataOe [*6])
        else $error("write data released too early");
    a_read_answer: assert property ($fell(oeN) |-> ##[1:4] devDataOe)
        else $error("device did not answer a read");
    a_abort_status: assert property ($rose(devDataOe) && $past(progAborted) |-> dq[ABORT_BIT] && !dq[LIMIT_BIT])
        else $error("abort status bits wrong");
    a_fail_status: assert property ($rose(devDataOe) && $past(progFailed) |-> dq[LIMIT_BIT])
        else $error("limit bit missing after failure");
    a_abort_not_busy: assert property (progBusy |=> !progAborted)
        else $error("running program turned into buffer abort");
    a_prog_bounded: assert property (progBusy |-> busyCnt < 10'd600)
        else $error("programming never finished");
    cover property ($rose(progAborted));
    cover property ($fell(progBusy));
    cover property ($rose(progFailed));
endmodule

// ===== core/fwb_flash_dev.sv
// Flash die program sequencer: word and write-buffer programming
module fwb_flash_dev
    import fwb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    fwb_flash_if.dev pins,
    output logic progBusy,
    output logic progAborted,
    output logic progFailed
);
    import fwb_pkg::*;

    function automatic logic [ADDR_W-SECTOR_LSB-1:0] sectorOf(input logic [ADDR_W-1:0] a);
        sectorOf = a[ADDR_W-1:SECTOR_LSB];
    endfunction

    function automatic logic [ADDR_W-PAGE_LSB-1:0] pageOf(input logic [ADDR_W-1:0] a);
        pageOf = a[ADDR_W-1:PAGE_LSB];
    endfunction

    logic [ADDR_W-1:0] addrS1, addrS2;
    logic [DATA_W-1:0] dqS1, dqS2;
    logic [3:0] ctlS1, ctlS2;
    logic strobePrev, oePrev;
    logic [ADDR_W-1:0] latchAddr;
    fwb_dev_state_t state;
    logic [DATA_W-1:0] bufData [BUF_WORDS];
    logic [BUF_WORDS-1:0] bufValid;
    logic [ADDR_W-PAGE_LSB-1:0] bufPage;
    logic [ADDR_W-SECTOR_LSB-1:0] bufSector;
    logic [5:0] loadsLeft;
    logic firstLoad;
    logic [DATA_W-1:0] statusData;
    logic [$clog2(PROG_CYCLES+1)-1:0] timer;
    logic toggle, altToggle;
    logic [DATA_W-1:0] mem [MEM_WORDS];
    logic [DATA_W-1:0] devData;
    logic devDataOe;

    logic strobeN, wrFall, wrRise, readNow, readEnd, progFinish, violation, statusMode;
    logic [DATA_W-1:0] wrData;

    // Pins pass two flops before use
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            addrS1 <= '0;
            addrS2 <= '0;
            dqS1 <= '0;
            dqS2 <= '0;
            ctlS1 <= 4'hf;
            ctlS2 <= 4'hf;
        end else if (clkEn) begin
            addrS1 <= pins.addr;
            addrS2 <= addrS1;
            dqS1 <= pins.dq;
            dqS2 <= dqS1;
            ctlS1 <= {pins.avdN, pins.ceN, pins.weN, pins.oeN};
            ctlS2 <= ctlS1;
        end
    end

    always_comb begin
        strobeN = ctlS2[2] | ctlS2[1];
        wrFall = strobePrev & ~strobeN;
        wrRise = ~strobePrev & strobeN;
        wrData = dqS2;
        readNow = ~ctlS2[2] & ~ctlS2[0] & ctlS2[1];
        readEnd = ~oePrev & ctlS2[0];
        statusMode = (state == DEV_BUSY) || (state == DEV_ABORT) || (state == DEV_FAIL);
        progFinish = (state == DEV_BUSY) && (timer == ($bits(timer))'(PROG_CYCLES - 1));
        violation = 1'b0;
        for (int i = 0; i < BUF_WORDS; i++) begin
            if (bufValid[i] && |(bufData[i] & ~mem[{bufPage, 5'(i)}])) begin
                violation = 1'b1;
            end
        end
    end

    // Address at strobe fall; data taken on rise
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            strobePrev <= 1'b1;
            oePrev <= 1'b1;
            latchAddr <= '0;
        end else if (clkEn) begin
            strobePrev <= strobeN;
            oePrev <= ctlS2[0];
            if (wrFall) begin
                latchAddr <= addrS2;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= DEV_READ;
            bufValid <= '0;
            bufPage <= '0;
            bufSector <= '0;
            loadsLeft <= '0;
            firstLoad <= 1'b0;
            statusData <= '0;
            timer <= '0;
            for (int i = 0; i < BUF_WORDS; i++) begin
                bufData[i] <= '0;
            end
        end else if (clkEn) begin
            if (state == DEV_BUSY) begin
                timer <= timer + 1'b1;
            end
            if (progFinish) begin
                state <= violation ? DEV_FAIL : DEV_READ;
            end else if (wrRise) begin
                unique case (state)
                    DEV_READ: begin
                        if (wrData == CMD_UNLOCK1 && latchAddr == UNLOCK_ADDR1) begin
                            state <= DEV_UNL1;
                        end
                    end
                    DEV_UNL1: begin
                        state <= (wrData == CMD_UNLOCK2 && latchAddr == UNLOCK_ADDR2) ? DEV_UNL2 : DEV_READ;
                    end
                    DEV_UNL2: begin
                        if (wrData == CMD_PROG && latchAddr == UNLOCK_ADDR1) begin
                            state <= DEV_PROG_DATA;
                        end else if (wrData == CMD_BUF_LOAD) begin
                            bufSector <= sectorOf(latchAddr);
                            state <= DEV_BUF_COUNT;
                        end else begin
                            state <= DEV_READ;
                        end
                    end
                    DEV_PROG_DATA: begin
                        bufValid <= BUF_WORDS'(1) << latchAddr[PAGE_LSB-1:0];
                        bufData[latchAddr[PAGE_LSB-1:0]] <= wrData;
                        bufPage <= pageOf(latchAddr);
                        statusData <= wrData;
                        timer <= '0;
                        state <= DEV_BUSY;
                    end
                    DEV_BUF_COUNT: begin
                        if (wrData > 16'(BUF_WORDS - 1) || sectorOf(latchAddr) != bufSector) begin
                            state <= DEV_ABORT;
                        end else begin
                            loadsLeft <= 6'(wrData[4:0]) + 6'h01;
                            firstLoad <= 1'b1;
                            bufValid <= '0;
                            state <= DEV_BUF_LOAD;
                        end
                    end
                    DEV_BUF_LOAD: begin
                        statusData <= wrData;
                        if (sectorOf(latchAddr) != bufSector) begin
                            state <= DEV_ABORT;
                        end else if (!firstLoad && pageOf(latchAddr) != bufPage) begin
                            state <= DEV_ABORT;
                        end else begin
                            firstLoad <= 1'b0;
                            if (firstLoad) begin
                                bufPage <= pageOf(latchAddr);
                            end
                            bufData[latchAddr[PAGE_LSB-1:0]] <= wrData;
                            bufValid[latchAddr[PAGE_LSB-1:0]] <= 1'b1;
                            loadsLeft <= loadsLeft - 6'h01;
                            if (loadsLeft == 6'h01) begin
                                state <= DEV_BUF_CONFIRM;
                            end
                        end
                    end
                    DEV_BUF_CONFIRM: begin
                        if (wrData == CMD_BUF_CONFIRM && sectorOf(latchAddr) == bufSector) begin
                            timer <= '0;
                            state <= DEV_BUSY;
                        end else begin
                            state <= DEV_ABORT;
                        end
                    end
                    DEV_BUSY: begin
                        if (wrData == CMD_SUSPEND) begin
                            state <= DEV_SUSPEND;
                        end
                    end
                    DEV_SUSPEND: begin
                        if (wrData == CMD_RESUME) begin
                            state <= DEV_BUSY;
                        end
                    end
                    DEV_ABORT, DEV_FAIL: begin
                        if (wrData == CMD_RESET) begin
                            state <= DEV_READ;
                        end
                    end
                endcase
            end
        end
    end

    // Array update at end of programming
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                mem[i] <= ERASED_WORD;
            end
        end else if (clkEn && progFinish && !violation) begin
            for (int i = 0; i < BUF_WORDS; i++) begin
                if (bufValid[i]) begin
                    mem[{bufPage, 5'(i)}] <= mem[{bufPage, 5'(i)}] & bufData[i];
                end
            end
        end
    end

    // Toggle bits advance after each status read
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            toggle <= 1'b0;
            altToggle <= 1'b0;
        end else if (clkEn && readEnd && statusMode) begin
            toggle <= ~toggle;
            altToggle <= ~altToggle;
        end
    end

    // Read path: status word or array data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            devData <= '0;
            devDataOe <= 1'b0;
        end else if (clkEn) begin
            devDataOe <= readNow;
            if (statusMode) begin
                devData <= '0;
                devData[POLL_BIT] <= ~statusData[POLL_BIT];
                devData[TOGGLE_BIT] <= toggle;
                devData[LIMIT_BIT] <= (state == DEV_FAIL);
                devData[ALT_TOGGLE_BIT] <= altToggle;
                devData[ABORT_BIT] <= (state == DEV_ABORT);
            end else begin
                devData <= mem[addrS2];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            progBusy <= 1'b0;
            progAborted <= 1'b0;
            progFailed <= 1'b0;
        end else if (clkEn) begin
            progBusy <= (state == DEV_BUSY) || (state == DEV_SUSPEND);
            progAborted <= (state == DEV_ABORT);
            progFailed <= (state == DEV_FAIL);
        end
    end

    assign pins.devData = devData;
    assign pins.devDataOe = devDataOe;
endmodule

// ===== core/fwb_flash_host.sv
// Host bus controller: Avalon-MM registers driving flash bus cycles
module fwb_flash_host
    import fwb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    fwb_flash_if.host pins
);
    import fwb_pkg::*;

    fwb_host_state_t state;
    logic [ADDR_W-1:0] regAddr, pinAddr;
    logic [DATA_W-1:0] regWdata, rdData, dqS1, dqS2, hostData;
    logic busy, isRead, avdN, ceN, weN, oeN, hostDataOe;
    logic [3:0] cnt;
    logic accept;

    assign accept = (avs_read | avs_write) & ~avs_waitrequest;

    // Avalon slave: one wait cycle per access
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
            regAddr <= '0;
            regWdata <= '0;
        end else if (clkEn) begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                unique case (avs_address)
                    REG_ADDR: avs_readdata <= 32'(regAddr);
                    REG_WDATA: avs_readdata <= 32'(regWdata);
                    REG_STATUS: avs_readdata <= {rdData, 15'h0000, busy};
                    default: avs_readdata <= '0;
                endcase
            end
            if (accept && avs_write && avs_address == REG_ADDR) begin
                regAddr <= avs_writedata[ADDR_W-1:0];
            end
            if (accept && avs_write && avs_address == REG_WDATA) begin
                regWdata <= avs_writedata[DATA_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dqS1 <= '0;
            dqS2 <= '0;
        end else if (clkEn) begin
            dqS1 <= pins.dq;
            dqS2 <= dqS1;
        end
    end

    // Pin cycle sequencer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= HST_IDLE;
            busy <= 1'b0;
            isRead <= 1'b0;
            cnt <= '0;
            rdData <= '0;
            pinAddr <= '0;
            hostData <= '0;
            hostDataOe <= 1'b0;
            avdN <= 1'b1;
            ceN <= 1'b1;
            weN <= 1'b1;
            oeN <= 1'b1;
        end else if (clkEn) begin
            cnt <= cnt + 4'h1;
            unique case (state)
                HST_IDLE: begin
                    cnt <= '0;
                    if (accept && avs_write && avs_address == REG_CTRL &&
                        (avs_writedata[CTRL_WRITE_BIT] || avs_writedata[CTRL_READ_BIT])) begin
                        isRead <= ~avs_writedata[CTRL_WRITE_BIT];
                        busy <= 1'b1;
                        pinAddr <= regAddr;
                        avdN <= 1'b0;
                        ceN <= 1'b0;
                        state <= HST_ADDR;
                    end
                end
                HST_ADDR: begin
                    if (cnt == 4'(STROBE_CYCLES - 1)) begin
                        cnt <= '0;
                        avdN <= 1'b1;
                        if (isRead) begin
                            oeN <= 1'b0;
                            state <= HST_READ;
                        end else begin
                            weN <= 1'b0;
                            hostData <= regWdata;
                            hostDataOe <= 1'b1;
                            state <= HST_STROBE;
                        end
                    end
                end
                HST_STROBE: begin
                    if (cnt == 4'(STROBE_CYCLES - 1)) begin
                        cnt <= '0;
                        weN <= 1'b1;
                        ceN <= 1'b1;
                        state <= HST_RELEASE;
                    end
                end
                HST_READ: begin
                    if (cnt == 4'(READ_CYCLES - 1)) begin
                        cnt <= '0;
                        rdData <= dqS2;
                        oeN <= 1'b1;
                        ceN <= 1'b1;
                        state <= HST_RELEASE;
                    end
                end
                HST_RELEASE: begin
                    if (cnt == 4'(STROBE_CYCLES - 1)) begin
                        hostDataOe <= 1'b0;
                        busy <= 1'b0;
                        state <= HST_IDLE;
                    end
                end
            endcase
        end
    end

    assign pins.addr = pinAddr;
    assign pins.avdN = avdN;
    assign pins.ceN = ceN;
    assign pins.weN = weN;
    assign pins.oeN = oeN;
    assign pins.hostData = hostData;
    assign pins.hostDataOe = hostDataOe;
endmodule

// ===== core/fwb_flash_if.sv
// Flash pin bundle joining host and device ends
interface fwb_flash_if;
    import fwb_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic avdN;
    logic ceN;
    logic weN;
    logic oeN;
    logic [DATA_W-1:0] hostData;
    logic hostDataOe;
    logic [DATA_W-1:0] devData;
    logic devDataOe;
    logic [DATA_W-1:0] dq;
    // Resolved data wire level
    assign dq = devDataOe ? devData : (hostDataOe ? hostData : ERASED_WORD);
    modport host (output addr, avdN, ceN, weN, oeN, hostData, hostDataOe, input dq);
    modport dev (input addr, avdN, ceN, weN, oeN, dq, output devData, devDataOe);
endinterface

// ===== core/fwb_pkg.sv
// Shared constants and types for the flash program sequencer and its host
package fwb_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int BUF_WORDS = 32;
    localparam int PAGE_LSB = 5;
    localparam int SECTOR_LSB = 8;
    localparam int MEM_WORDS = 4096;
    localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00aa;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROG = 16'h00a0;
    localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
    localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
    localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
    localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
    localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 12'h2aa;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 2000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYCLES = 6;
    localparam int READ_CYCLES = 8;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int LIMIT_BIT = 5;
    localparam int ALT_TOGGLE_BIT = 2;
    localparam int ABORT_BIT = 1;
    localparam logic [3:0] REG_ADDR = 4'h0;
    localparam logic [3:0] REG_WDATA = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CTRL_WRITE_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    typedef enum logic [3:0] {
        DEV_READ, DEV_UNL1, DEV_UNL2, DEV_PROG_DATA, DEV_BUF_COUNT, DEV_BUF_LOAD,
        DEV_BUF_CONFIRM, DEV_BUSY, DEV_SUSPEND, DEV_ABORT, DEV_FAIL
    } fwb_dev_state_t;
    typedef enum logic [2:0] {HST_IDLE, HST_ADDR, HST_STROBE, HST_READ, HST_RELEASE} fwb_host_state_t;
endpackage
